/* File: logic/irq_pending_and_control.sv */
// pending flags, control/status register, reset vector select and event
// interrupt of the interrupt controller's last stage.
// assumes: request lines and core acknowledge on MCLK; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module irq_pending_and_control
   import irq_ctl_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic SYS_RST,
   // avalon-mm slave, byte address
   input wire logic [6:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // request sources, bit i is vector i+2, active high level
   input wire logic [NUM_VEC-1:0] IRQ_REQ,
   input wire logic EXT_REQUEST_PIN_A_N,
   input wire logic EXT_REQUEST_PIN_B_N,
   input wire logic LOW_PWR,
   // processor core side
   input wire logic CORE_ACK,
   output logic CORE_IRQ,
   output logic [6:0] CORE_VEC,
   output logic [1:0] CORE_LEVEL,
   output logic RST_VEC_SEL,
   output logic FIXED_EXC_EN,
   // event interrupt
   output logic IRQ_LINE
);

   state_t q;
   state_t d;
   logic [4:0] idx;
   logic taken;
   logic edge_mode_a;
   logic edge_mode_b;
   logic fall_a;
   logic fall_b;
   logic pin_a_req;
   logic pin_b_req;
   logic [NUM_VEC-1:0] req;
   logic [NUM_VEC-1:0] en_bits;
   logic [NUM_VEC-1:0] act;
   logic [95:0] img;
   logic [15:0] ctl_rd;
   logic [31:0] rd_mux;
   logic wr_hit;
   logic [NUM_EV-1:0] ev;
   logic [NUM_EV-1:0] clr;

   // lowest vector number wins; vectors carry no programmable priority here
   function automatic logic [6:0] first_vec(input logic [NUM_VEC-1:0] p);
      logic [6:0] v;
      v = 7'h00;
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
         if (p[i]) begin
            v = 7'(i + FIRST_VEC);
         end
      end
      return v;
   endfunction

   // next-state logic for the whole block
   always_comb begin
      d = q;
      idx = AVS_ADDRESS[6:2];
      // pins pass two flops; the logic reads only the second stage
      d.sync_a = {q.sync_a[0], EXT_REQUEST_PIN_A_N};
      d.sync_b = {q.sync_b[0], EXT_REQUEST_PIN_B_N};
      d.prev_a = q.sync_a[1];
      d.prev_b = q.sync_b[1];
      taken = CORE_ACK & q.core_irq;
      edge_mode_a = q.edge_a & ~LOW_PWR;
      edge_mode_b = q.edge_b & ~LOW_PWR;
      fall_a = q.prev_a & ~q.sync_a[1];
      fall_b = q.prev_b & ~q.sync_b[1];
      // latch until taken; a new edge beats the clear
      if (edge_mode_a && fall_a) begin
         d.latch_a = 1'b1;
      end else if ((taken && q.core_vec == PIN_A_VEC) || !q.edge_a) begin
         d.latch_a = 1'b0;
      end
      if (edge_mode_b && fall_b) begin
         d.latch_b = 1'b1;
      end else if ((taken && q.core_vec == PIN_B_VEC) || !q.edge_b) begin
         d.latch_b = 1'b0;
      end
      // level mode pends while pin low
      pin_a_req = edge_mode_a ? q.latch_a : ~q.sync_a[1];
      pin_b_req = edge_mode_b ? q.latch_b : ~q.sync_b[1];
      req = IRQ_REQ;
      req[int'(PIN_A_VEC) - FIRST_VEC] = IRQ_REQ[int'(PIN_A_VEC) - FIRST_VEC] | pin_a_req;
      req[int'(PIN_B_VEC) - FIRST_VEC] = IRQ_REQ[int'(PIN_B_VEC) - FIRST_VEC] | pin_b_req;
      d.pend_n = ~req;
      // per-word enables; word k holds vectors 16k+1 .. 16k+16
      for (int i = 0; i < NUM_VEC; i++) begin
         en_bits[i] = q.word_en[(i + 1) / 16];
      end
      act = ~q.pend_n & en_bits;
      d.core_irq = (|act) & ~q.mask & ~q.rst_vec;
      d.core_vec = first_vec(act);
      d.core_level = LEVEL_CODE;
      if (taken) begin
         d.taken_vec = q.core_vec;
         d.taken_level = q.core_level;
      end
      if (q.rst_cnt != RST_VEC_HOLD) begin
         d.rst_cnt = q.rst_cnt + 2'h1;
      end
      d.rst_vec = (d.rst_cnt != RST_VEC_HOLD);
      d.fixed_en = 1'b1;
      // word 5 upper bits fixed at one
      img = {15'h7fff, q.pend_n, 1'b1};
      // bit 15 mirrors request; bit 4 reads one; pin levels
      ctl_rd = {q.core_irq, q.taken_level, q.taken_vec, q.mask, 1'b1,
                q.sync_b[1], q.sync_a[1], q.edge_b, q.edge_a};
      // read mux; reserved and unmapped words read zero
      rd_mux = 32'h0000_0000;
      if (idx >= IDX_PEND0 && idx <= IDX_PEND5) begin
         rd_mux = {16'h0000, img[(int'(idx) - int'(IDX_PEND0)) * 16 +: 16]};
      end else if (idx == IDX_CTL) begin
         rd_mux = {16'h0000, ctl_rd};
      end else if (idx == IDX_WORD_EN) begin
         rd_mux = {26'h0000000, q.word_en};
      end else if (idx == IDX_INT_STAT) begin
         rd_mux = {29'h00000000, q.int_stat};
      end else if (idx == IDX_INT_EN) begin
         rd_mux = {29'h00000000, q.int_en};
      end
      // one wait cycle, then answer; read data caught in the wait cycle
      d.ack = (AVS_READ | AVS_WRITE) & ~q.ack;
      if (AVS_READ && !q.ack) begin
         d.rdata = rd_mux;
      end
      // writes act at the edge where the master sees waitrequest low
      wr_hit = AVS_WRITE & q.ack & AVS_BYTEENABLE[0];
      clr = '0;
      if (wr_hit) begin
         case (idx)
            IDX_CTL: begin
               d.mask = AVS_WRITEDATA[CTL_MASK_BIT];
               d.edge_b = AVS_WRITEDATA[CTL_EDGE_B_BIT];
               d.edge_a = AVS_WRITEDATA[CTL_EDGE_A_BIT];
            end
            IDX_WORD_EN: begin
               d.word_en = AVS_WRITEDATA[NUM_WORDS-1:0];
            end
            IDX_INT_EN: begin
               d.int_en = AVS_WRITEDATA[NUM_EV-1:0];
            end
            IDX_INT_CLR: begin
               clr = AVS_WRITEDATA[NUM_EV-1:0];
            end
            default: begin
               clr = '0;
            end
         endcase
      end
      // sticky events; a set in the clearing cycle survives
      ev = '0;
      ev[EV_PIN_A] = edge_mode_a & fall_a;
      ev[EV_PIN_B] = edge_mode_b & fall_b;
      ev[EV_TAKEN] = taken;
      d.int_stat = (q.int_stat & ~clr) | ev;
      d.irq_line = |(d.int_stat & d.int_en);
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         q <= STATE_RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state flops
   assign AVS_READDATA = q.rdata;
   assign AVS_WAITREQUEST = ~q.ack;
   assign CORE_IRQ = q.core_irq;
   assign CORE_VEC = q.core_vec;
   assign CORE_LEVEL = q.core_level;
   assign RST_VEC_SEL = q.rst_vec;
   assign FIXED_EXC_EN = q.fixed_en;
   assign IRQ_LINE = q.irq_line;

   // checks on the design's own outputs and state
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SYS_RST);

   sequence rd_done_s(logic [4:0] w);
      !AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS[6:2] == w;
   endsequence

   sequence pin_a_fall_s;
      q.edge_a && !LOW_PWR && q.prev_a && !q.sync_a[1];
   endsequence

   sequence core_takes_s;
      CORE_ACK && CORE_IRQ;
   endsequence

   pend_flag_a: assert property (
      $stable(IRQ_REQ[0]) && $past(IRQ_REQ[0]) |-> q.pend_n[0] == 1'b0)
      else $error("vector 2 request not shown as pending");
   word5_high_a: assert property (
      rd_done_s(IDX_PEND5) |-> AVS_READDATA[31:1] == 31'h00007fff)
      else $error("upper bits of last pending word not one");
   rsv_word_a: assert property (
      !AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS[6:2] >= IDX_RSV_LO
      && AVS_ADDRESS[6:2] <= IDX_RSV_HI |-> AVS_READDATA == 32'h0000_0000)
      else $error("reserved word read nonzero");
   irq_mirror_a: assert property (
      rd_done_s(IDX_CTL) |-> AVS_READDATA[15] == $past(CORE_IRQ))
      else $error("bit 15 does not mirror core request");
   taken_capture_a: assert property (
      core_takes_s |=> q.taken_vec == $past(CORE_VEC)
      && q.taken_level == $past(CORE_LEVEL) && q.taken_level == LEVEL_CODE)
      else $error("taken level or vector not captured");
   taken_hold_a: assert property (
      !(CORE_ACK && CORE_IRQ) |=> $stable(q.taken_vec) && $stable(q.taken_level))
      else $error("taken fields changed without entry");
   mask_block_a: assert property (
      q.mask ##1 q.mask |-> !CORE_IRQ)
      else $error("request sent while globally masked");
   bit4_one_a: assert property (
      rd_done_s(IDX_CTL) |-> AVS_READDATA[4] == 1'b1 && AVS_READDATA[3:2] == $past(
      {q.sync_b[1], q.sync_a[1]}))
      else $error("bit 4 or pin level bits wrong");
   edge_latch_a: assert property (
      pin_a_fall_s |=> q.latch_a ##1 (q.latch_a || $past(CORE_ACK) || !$past(q.edge_a)))
      else $error("pin edge not latched");
   low_pwr_a: assert property (
      LOW_PWR |-> pin_a_req == ~q.sync_a[1] && pin_b_req == ~q.sync_b[1])
      else $error("pin not level-sensitive in low power");
   rst_vec_a: assert property (
      $fell(SYS_RST) |-> RST_VEC_SEL ##1 RST_VEC_SEL ##1 !RST_VEC_SEL)
      else $error("reset vector held wrong number of edges");
   rst_dflt_a: assert property (
      $fell(SYS_RST) |-> q.word_en == '0 && !q.mask && q.edge_a == 1'b0 && !CORE_IRQ)
      else $error("reset defaults wrong");
   fixed_en_a: assert property (
      $past(SYS_RST) ##1 1'b1 |-> FIXED_EXC_EN ##1 FIXED_EXC_EN)
      else $error("fixed exceptions disabled");

   // a completed write with the low byte enabled
   sequence wr_done_s(logic [4:0] w);
      !AVS_WAITREQUEST && AVS_WRITE && AVS_BYTEENABLE[0] && AVS_ADDRESS[6:2] == w;
   endsequence

   // bus: a waiting request is answered at the very next edge
   req_answer_a: assert property (
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus request not answered after one wait cycle");
   // the answer stands one cycle only, so a held request is not taken twice
   answer_once_a: assert property (
      !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");
   // after an idle cycle the bus always sees waitrequest high
   idle_wait_a: assert property (
      !AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
      else $error("waitrequest low without a request");
   // read data only moves while a read waits, so the master sees it settled
   rdata_hold_a: assert property (
      !(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
      else $error("read data changed outside a read");
   // registers are 16 bits wide; the upper half of the bus word is zero
   rdata_upper_a: assert property (
      !AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0000)
      else $error("upper read data bits not zero");
   // writes with the low byte disabled leave every register alone
   be_ignore_a: assert property (
      AVS_WRITE && !AVS_BYTEENABLE[0] |=> $stable(q.mask) && $stable(q.edge_a)
      && $stable(q.edge_b) && $stable(q.word_en) && $stable(q.int_en))
      else $error("write landed with byte enable low");
   // word 0 bit 0 has no vector behind it
   word0_bit0_a: assert property (
      rd_done_s(IDX_PEND0) |-> AVS_READDATA[0] == 1'b1)
      else $error("bit 0 of first pending word not one");
   // a request only goes out for a vector that exists
   vec_range_a: assert property (
      CORE_IRQ |-> CORE_VEC >= 7'(FIRST_VEC) && CORE_VEC <= 7'(FIRST_VEC + NUM_VEC - 1))
      else $error("request carries a vector out of range");
   // no request reaches the core while the reset vector is shown
   rst_block_a: assert property (
      q.rst_vec |=> !CORE_IRQ)
      else $error("request sent during reset vector");
   // the fixed level code goes with every request
   level_code_a: assert property (
      CORE_IRQ |-> CORE_LEVEL == LEVEL_CODE)
      else $error("wrong level code with request");
   // one masked cycle is enough to hold the request down
   mask_next_a: assert property (
      q.mask |=> !CORE_IRQ)
      else $error("request raised after masked cycle");
   // a control write takes the mask and both edge selects
   ctl_write_a: assert property (
      wr_done_s(IDX_CTL) |=> q.mask == $past(AVS_WRITEDATA[CTL_MASK_BIT])
      && q.edge_b == $past(AVS_WRITEDATA[CTL_EDGE_B_BIT])
      && q.edge_a == $past(AVS_WRITEDATA[CTL_EDGE_A_BIT]))
      else $error("control write not taken");
   // level mode: a low pin A pends its vector
   level_pend_a: assert property (
      !q.edge_a && !q.sync_a[1] |=> !q.pend_n[int'(PIN_A_VEC) - FIRST_VEC])
      else $error("low pin A not pending in level mode");
   // level mode: a low pin B pends its vector
   level_pend_b_a: assert property (
      !q.edge_b && !q.sync_b[1] |=> !q.pend_n[int'(PIN_B_VEC) - FIRST_VEC])
      else $error("low pin B not pending in level mode");
   // edge mode: a low level alone does not pend
   edge_quiet_a: assert property (
      q.edge_a && !LOW_PWR && !q.latch_a && !IRQ_REQ[int'(PIN_A_VEC) - FIRST_VEC]
      |=> q.pend_n[int'(PIN_A_VEC) - FIRST_VEC])
      else $error("pin A pending without an edge");
   // low power: a low pin pends even with edge select set
   lp_level_a: assert property (
      LOW_PWR && !q.sync_b[1] |=> !q.pend_n[int'(PIN_B_VEC) - FIRST_VEC])
      else $error("low pin B not pending in low power");
   // with every word disabled nothing is sent
   word_gate_a: assert property (
      CORE_IRQ |-> $past(q.word_en) != '0)
      else $error("request sent with all words disabled");
   // word enables are software's to set
   word_write_a: assert property (
      wr_done_s(IDX_WORD_EN) |=> q.word_en == $past(AVS_WRITEDATA[NUM_WORDS-1:0]))
      else $error("word enable write not taken");
   // taking pin A's vector clears its latch unless a new edge arrives
   latch_clear_a: assert property (
      q.latch_a && CORE_ACK && CORE_IRQ && CORE_VEC == PIN_A_VEC
      && !(q.edge_a && !LOW_PWR && q.prev_a && !q.sync_a[1]) |=> !q.latch_a)
      else $error("pin A latch kept after take");
   // a stale latch must not survive a switch to level mode
   latch_off_a: assert property (
      !q.edge_a |=> !q.latch_a)
      else $error("pin A latch set in level mode");
   latch_off_b_a: assert property (
      !q.edge_b |=> !q.latch_b)
      else $error("pin B latch set in level mode");
   // the captured vector is always a real one
   taken_vec_a: assert property (
      core_takes_s |=> q.taken_vec >= 7'(FIRST_VEC))
      else $error("captured vector out of range");
   // events: each one sets its sticky bit
   ev_pin_a_a: assert property (
      pin_a_fall_s |=> q.int_stat[EV_PIN_A])
      else $error("pin A edge event not recorded");
   ev_taken_a: assert property (
      core_takes_s |=> q.int_stat[EV_TAKEN])
      else $error("take event not recorded");
   // a status bit stays until software clears it
   ev_sticky_a: assert property (
      q.int_stat[EV_TAKEN] && !(AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
      && AVS_ADDRESS[6:2] == IDX_INT_CLR && AVS_WRITEDATA[EV_TAKEN]) |=> q.int_stat[EV_TAKEN])
      else $error("take status lost without clear");
   // a clear empties the bit when no new event falls in that cycle
   ev_clear_a: assert property (
      wr_done_s(IDX_INT_CLR) ##0 (AVS_WRITEDATA[EV_TAKEN] && !(CORE_ACK && CORE_IRQ))
      |=> !q.int_stat[EV_TAKEN])
      else $error("take status not cleared");
   // the line follows enabled status with no extra delay
   line_a: assert property (
      IRQ_LINE == |(q.int_stat & q.int_en))
      else $error("event line does not match enabled status");

endmodule
`default_nettype wire

/* File: logic/irq_ctl_pkg.sv */
// constants, field positions, reset values and state layout of the interrupt
// pending and control block; assumes 16-bit registers on a 32-bit bus.
package irq_ctl_pkg;
   // register word indexes; byte address is four times the index
   localparam logic [4:0] IDX_INT_CLR = 5'h0f;
   localparam logic [4:0] IDX_INT_EN = 5'h10;
   localparam logic [4:0] IDX_PEND0 = 5'h11;
   localparam logic [4:0] IDX_PEND5 = 5'h16;
   localparam logic [4:0] IDX_RSV_LO = 5'h17;
   localparam logic [4:0] IDX_RSV_HI = 5'h1c;
   localparam logic [4:0] IDX_CTL = 5'h1d;
   localparam logic [4:0] IDX_WORD_EN = 5'h1e;
   localparam logic [4:0] IDX_INT_STAT = 5'h1f;
   // control register writable field positions
   localparam int CTL_MASK_BIT = 5;
   localparam int CTL_EDGE_B_BIT = 1;
   localparam int CTL_EDGE_A_BIT = 0;
   // vectors served by the external pins
   localparam logic [6:0] PIN_A_VEC = 7'h41;
   localparam logic [6:0] PIN_B_VEC = 7'h42;
   localparam int FIRST_VEC = 2;
   localparam int NUM_VEC = 80;
   localparam int NUM_WORDS = 6;
   // level code presented with every request: nesting needs level 1 or above
   localparam logic [1:0] LEVEL_CODE = 2'h1;
   // cycles after reset release during which the reset vector is still shown
   localparam logic [1:0] RST_VEC_HOLD = 2'h2;
   // sticky event bits
   localparam int EV_PIN_A = 0;
   localparam int EV_PIN_B = 1;
   localparam int EV_TAKEN = 2;
   localparam int NUM_EV = 3;

   typedef struct packed {
      logic [1:0] sync_a;
      logic [1:0] sync_b;
      logic prev_a;
      logic prev_b;
      logic latch_a;
      logic latch_b;
      logic [NUM_VEC-1:0] pend_n;
      logic [NUM_WORDS-1:0] word_en;
      logic mask;
      logic edge_b;
      logic edge_a;
      logic core_irq;
      logic [6:0] core_vec;
      logic [1:0] core_level;
      logic [1:0] taken_level;
      logic [6:0] taken_vec;
      logic [1:0] rst_cnt;
      logic rst_vec;
      logic ack;
      logic [31:0] rdata;
      logic [NUM_EV-1:0] int_stat;
      logic [NUM_EV-1:0] int_en;
      logic irq_line;
      logic fixed_en;
   } state_t;

   localparam state_t STATE_RST = '{sync_a: 2'h3, sync_b: 2'h3, prev_a: 1'b1, prev_b: 1'b1,
      pend_n: {NUM_VEC{1'b1}}, rst_vec: 1'b1, fixed_en: 1'b1, default: '0};
endpackage

/* File: tb/core_model.sv */
// core model: takes each raised request once, after a chosen delay
// assumes request and take pulse both on MCLK
`timescale 1ns/1ps
`default_nettype none
module core_model (
   // clock and reset
   input wire logic MCLK,
   input wire logic SYS_RST,
   // request link
   input wire logic CORE_IRQ,
   input wire logic [3:0] DELAY,
   output logic CORE_ACK
);
   logic [3:0] cnt_q;
   logic done_q;
   // act on request level
   // a request that stays up is taken once, so a level source is not re-entered
   always @(posedge MCLK) begin
      CORE_ACK <= 1'b0;
      if (SYS_RST || !CORE_IRQ) begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end else if (!done_q && cnt_q == DELAY) begin
         CORE_ACK <= 1'b1;
         done_q <= 1'b1;
      end else if (!done_q) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule
`default_nettype wire

/* File: tb/irq_pending_and_control_bench.sv */
// bench for the pending and control block, driving its bus and pins
// assumes one 10 MHz clock, synchronous reset and the core model
`timescale 1ns/1ps
`default_nettype none
module irq_pending_and_control_bench;
   import irq_ctl_pkg::*;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wrq = 1'b0, pa = 1'b1, pb = 1'b1, lp = 1'b0;
   logic ack, wq, irq, rsel, fix, line;
   logic [6:0] adr = '0, vec;
   logic [1:0] lvl;
   logic [3:0] be = '0, dly = '0;
   logic [31:0] wd = '0, rdat, st = 32'h2ad7a26e;
   logic [NUM_VEC-1:0] req = '0;
   logic [15:0] notes[$];
   int bad_count = 0, samples_checked = 0, v, k;
   // clock
   always #50 clk = ~clk;
   irq_pending_and_control i_dut (.MCLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wrq), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wd), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wq), .IRQ_REQ(req), .EXT_REQUEST_PIN_A_N(pa), .EXT_REQUEST_PIN_B_N(pb),
      .LOW_PWR(lp), .CORE_ACK(ack), .CORE_IRQ(irq), .CORE_VEC(vec), .CORE_LEVEL(lvl),
      .RST_VEC_SEL(rsel), .FIXED_EXC_EN(fix), .IRQ_LINE(line));
   core_model i_core (.MCLK(clk), .SYS_RST(rst), .CORE_IRQ(irq), .DELAY(dly), .CORE_ACK(ack));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bit_chk(input logic got, input logic exp);
      chk({15'h0, got}, {15'h0, exp});
   endtask
   // one avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] idx, input logic [15:0] d,
      input logic [3:0] b);
      @(posedge clk);
      rd <= !w;
      wrq <= w;
      adr <= {idx, 2'b00};
      wd <= {16'h0, d};
      be <= b;
      do @(posedge clk); while (wq !== 1'b0);
      rd <= 1'b0;
      wrq <= 1'b0;
   endtask
   task automatic rdx(input logic [4:0] idx, input logic [15:0] exp);
      notes.push_back(exp);
      bus(1'b0, idx, 16'h0, 4'h0);
   endtask
   task automatic wr(input logic [4:0] idx, input logic [15:0] d);
      bus(1'b1, idx, d, 4'h1);
   endtask
   // bounded wait for the core model to take a request
   task automatic wait_take();
      int n;
      n = 0;
      while (ack !== 1'b1 && n < 60) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
   endtask
   // read data is compared at the edge where the master takes it
   always @(posedge clk) begin
      if (rd && wq === 1'b0) chk(rdat[15:0], notes.pop_front());
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // watchdog: the whole run needs far fewer than 20000 cycles
   initial begin
      #2000000;
      bad_count++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge clk);
      bit_chk(rsel, 1'b1);
      rst <= 1'b0;
      @(posedge clk);
      #1 bit_chk(rsel, 1'b1);
      @(posedge clk);
      #1 bit_chk(rsel, 1'b0);
      bit_chk(fix, 1'b1);
      for (k = 0; k < NUM_WORDS; k++) rdx(IDX_PEND0 + 5'(k), 16'hffff);
      rdx(IDX_CTL, 16'h001c);
      rdx(IDX_RSV_LO, 16'h0);
      rdx(IDX_RSV_HI, 16'h0);
      rdx(5'h0e, 16'h0);
      rdx(IDX_WORD_EN, 16'h0);
      rdx(IDX_INT_EN, 16'h0);
      $display("reset test done");
      wr(IDX_CTL, 16'hffff);
      rdx(IDX_CTL, 16'h003f);
      bus(1'b1, IDX_CTL, 16'h0, 4'h0);
      rdx(IDX_CTL, 16'h003f);
      wr(IDX_PEND5, 16'h0);
      rdx(IDX_PEND5, 16'hffff);
      wr(IDX_CTL, 16'h0);
      $display("control test done");
      // random vectors, each taken after a random core delay
      for (int i = 0; i < 4; i++) begin
         st = lfsr(st);
         v = 2 + st % 80;
         k = (v - 1) / 16;
         dly <= st[11:8];
         req <= NUM_VEC'(1) << (v - 2);
         rdx(IDX_PEND0 + 5'(k), ~(16'h1 << ((v - 1) % 16)));
         wr(IDX_WORD_EN, 16'h1 << k);
         wait_take();
         rdx(IDX_CTL, 16'ha01c | (16'(v) << 6));
         wr(IDX_CTL, 16'h0020);
         rdx(IDX_CTL, 16'h203c | (16'(v) << 6));
         req <= '0;
         wr(IDX_CTL, 16'h0);
         wr(IDX_WORD_EN, 16'h0);
      end
      $display("request test done");
      rdx(IDX_INT_STAT, 16'h4);
      bit_chk(line, 1'b0);
      wr(IDX_INT_EN, 16'h4);
      rdx(IDX_INT_EN, 16'h4);
      bit_chk(line, 1'b1);
      wr(IDX_INT_CLR, 16'h7);
      rdx(IDX_INT_STAT, 16'h0);
      bit_chk(line, 1'b0);
      $display("event test done");
      wr(IDX_CTL, 16'h0001);
      wr(IDX_WORD_EN, 16'h0010);
      pa <= 1'b0;
      wait_take();
      pa <= 1'b1;
      rdx(IDX_INT_STAT, 16'h5);
      rdx(IDX_CTL, 16'h305d);
      $display("edge test done");
      lp <= 1'b1;
      pa <= 1'b0;
      pb <= 1'b0;
      wait_take();
      rdx(IDX_CTL, 16'hb051);
      pa <= 1'b1;
      pb <= 1'b1;
      lp <= 1'b0;
      $display("low power test done");
      final_report();
   end
endmodule
`default_nettype wire
